//--- design/mtta_curve.sv
// Frequency weighted protection level for the thermal integrator
`timescale 1ns/1ps
`default_nettype none
module mtta_curve
    import mtta_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [1:0]  curve_sel_in,
    input  wire logic [15:0] level_in,
    input  wire logic [15:0] freq_in,
    input  wire logic [47:0] bp_freq_in,
    input  wire logic [47:0] bp_cur_in,
    output logic      [15:0] eff_level_out
);
    logic [15:0] eff_ff;
    logic [15:0] nxt_eff;
    logic [31:0] factor;
    logic [31:0] prod;

    always_comb
    begin
        factor = {16'h0000, RATED_PM};
        prod   = 32'h0000_0000;
        nxt_eff = level_in;
        case (curve_sel_in)
            CURVE_REDUCED:
            begin
                // Poor self cooling at low speed lowers the allowed load
                if (freq_in < RT_KNEE_HZ)
                    factor = {16'h0000, RT_FACTOR_LOW}
                           + ({16'h0000, RATED_PM - RT_FACTOR_LOW}
                              * {16'h0000, freq_in}) / {16'h0000, RT_KNEE_HZ};
                prod    = {16'h0000, level_in} * factor;
                nxt_eff = 16'(prod / {16'h0000, RATED_PM});
            end
            CURVE_CONST:
                nxt_eff = level_in;
            CURVE_FREE:
            begin
                if (freq_in <= bp_freq_in[15:0])
                    nxt_eff = bp_cur_in[15:0];
                else if (freq_in <= bp_freq_in[31:16])
                    nxt_eff = bp_cur_in[31:16];
                else
                    nxt_eff = bp_cur_in[47:32];
            end
            default:
                nxt_eff = level_in;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            eff_ff <= LEVEL_RST;
        else
            eff_ff <= nxt_eff;
    end

    assign eff_level_out = eff_ff;
endmodule
`default_nettype wire

//--- design/mtta_pkg.sv
// Constants shared by the motor thermal trip and alarm block
package mtta_pkg;
    localparam int unsigned CLK_HZ        = 32'h017D_7840; // 25 MHz
    localparam int unsigned TICK_US       = 32'h0000_03E8; // 1000 us
    localparam int unsigned TICK_CYC      = CLK_HZ / 32'h000F_4240 * TICK_US;
    localparam int unsigned THERM_FULL    = 32'h01C9_C380; // 100 % heat
    localparam int unsigned DECAY_SHIFT   = 32'h0000_0004;

    localparam logic [4:0] REG_CTRL       = 5'h00;
    localparam logic [4:0] REG_LEVEL1     = 5'h01;
    localparam logic [4:0] REG_LEVEL2     = 5'h02;
    localparam logic [4:0] REG_BP_FREQ0   = 5'h03;
    localparam logic [4:0] REG_BP_CUR0    = 5'h06;
    localparam logic [4:0] REG_WARN_THR   = 5'h09;
    localparam logic [4:0] REG_OUT11_FN   = 5'h0A;
    localparam logic [4:0] REG_RELAY_FN   = 5'h0B;
    localparam logic [4:0] REG_IN_FN0     = 5'h0C;
    localparam logic [4:0] REG_STATUS     = 5'h11;
    localparam logic [4:0] REG_MONITOR    = 5'h12;

    localparam int unsigned CTRL_CURVE_LSB = 32'h0000_0000;
    localparam int unsigned CTRL_SET2_BIT  = 32'h0000_0002;
    localparam int unsigned ST_TRIP_BIT    = 32'h0000_0000;
    localparam int unsigned ST_LOCK_BIT    = 32'h0000_0001;
    localparam int unsigned ST_WARN_BIT    = 32'h0000_0002;
    localparam int unsigned ST_CODE_LSB    = 32'h0000_0008;

    localparam logic [1:0] CURVE_REDUCED  = 2'h0;
    localparam logic [1:0] CURVE_CONST    = 2'h1;
    localparam logic [1:0] CURVE_FREE     = 2'h2;

    localparam logic [7:0] FN_FAULT       = 8'h05;
    localparam logic [7:0] FN_WARN        = 8'h0D;
    localparam logic [7:0] FN_RESET       = 8'h12;
    localparam logic [7:0] OVL_TRIP_CODE  = 8'h05;
    localparam logic [7:0] EXT_CODE_BASE  = 8'h10;

    // Levels are in per mille of rated current
    localparam logic [15:0] RATED_PM      = 16'h03E8;
    localparam logic [15:0] LEVEL_MIN     = 16'h00C8;
    localparam logic [15:0] LEVEL_RST     = 16'h03E8;
    localparam logic [15:0] BP_FREQ_MAX   = 16'h0190;
    localparam logic [15:0] RT_FACTOR_LOW = 16'h0320;
    localparam logic [15:0] RT_KNEE_HZ    = 16'h0014;
    localparam logic [7:0]  WARN_MAX      = 8'h64;
    localparam logic [7:0]  PCT_FULL      = 8'h64;
    localparam logic [7:0]  OUT11_RST     = 8'h00;
    localparam logic [7:0]  RELAY_RST     = 8'h05;
endpackage

//--- design/mtta_thermal_integ.sv
// Thermal accumulator with percent monitor, warning and trip flags
`timescale 1ns/1ps
`default_nettype none
module mtta_thermal_integ
    import mtta_pkg::*;
#(
    parameter int unsigned FULL = THERM_FULL
)
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        tick_in,
    input  wire logic [15:0] current_in,
    input  wire logic [15:0] eff_level_in,
    input  wire logic [7:0]  warn_thr_in,
    output logic      [7:0]  percent_out,
    output logic             full_out,
    output logic             warn_out
);
    localparam logic [31:0] CAP = 32'(FULL) * 32'h0000_0002;

    logic [31:0] acc_ff;
    logic [31:0] nxt_acc;
    logic [7:0]  pct_ff;
    logic [7:0]  nxt_pct;
    logic [32:0] sum;
    logic [15:0] dec;

    always_comb
    begin
        sum     = {1'b0, acc_ff};
        dec     = 16'h0000;
        nxt_acc = acc_ff;
        if (tick_in)
        begin
            if (current_in > eff_level_in)
            begin
                sum = {1'b0, acc_ff} + {17'h0_0000, current_in - eff_level_in};
                nxt_acc = (sum > {1'b0, CAP}) ? CAP : sum[31:0];
            end
            else
            begin
                dec = (eff_level_in - current_in) >> DECAY_SHIFT;
                nxt_acc = (acc_ff > {16'h0000, dec})
                        ? acc_ff - {16'h0000, dec} : 32'h0000_0000;
            end
        end
        nxt_pct = 8'((40'(acc_ff) * 40'h00_0000_0064) / 40'(FULL));
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            acc_ff <= 32'h0000_0000;
            pct_ff <= 8'h00;
        end
        else
        begin
            acc_ff <= nxt_acc;
            pct_ff <= nxt_pct;
        end
    end

    assign percent_out = pct_ff;
    assign full_out    = (pct_ff >= PCT_FULL);
    assign warn_out    = (warn_thr_in != 8'h00)
                       && (pct_ff >= warn_thr_in);

    full_pct_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (acc_ff >= FULL) |=> full_out)
        else $error("Trip flag missing at full heat");
    warn_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (warn_thr_in == 8'h00) |-> !warn_out)
        else $error("Warning raised while disabled");
    heat_rise_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (tick_in && current_in > eff_level_in && acc_ff < CAP)
        |=> acc_ff > $past(acc_ff))
        else $error("Accumulator did not rise under overload");
endmodule
`default_nettype wire

//--- design/mtta_top.sv
// Motor trip, alarm routing and electronic thermal protection
`timescale 1ns/1ps
`default_nettype none
module mtta_top
    import mtta_pkg::*;
#(
    parameter int unsigned N_CAUSE     = 8,
    parameter logic [7:0]  POWER_CYCLE = 8'h80,
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned FULL        = THERM_FULL
)
(
    input  wire logic               clk_in,
    input  wire logic               sys_rst_in,
    input  wire logic [4:0]         addr_in,
    input  wire logic [15:0]        wdata_in,
    input  wire logic               wr_in,
    input  wire logic               rd_in,
    output logic      [15:0]        rdata_out,
    input  wire logic [N_CAUSE-1:0] fault_cause_in,
    input  wire logic               panel_stop_reset_key_in,
    input  wire logic [4:0]         general_inputs_in,
    input  wire logic [15:0]        current_in,
    input  wire logic [15:0]        freq_in,
    output logic                    power_enable_out,
    output logic                    fault_indication_out,
    output logic                    overheat_warning_out,
    output logic                    general_output_11_out,
    output logic                    relay_output_out,
    output logic      [7:0]         trip_code_out
);
    typedef enum logic [1:0] {ST_RUN, ST_TRIP, ST_LOCK} mtta_state_t;

    function automatic logic route(input logic [7:0] fn,
                                   input logic fault, input logic warn);
        route = (fn == FN_FAULT) ? fault : (fn == FN_WARN) ? warn : 1'b0;
    endfunction

    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        clamp = (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction

    // Software registers
    logic [2:0]  ctrl_ff,   nxt_ctrl;
    logic [15:0] lvl1_ff,   nxt_lvl1;
    logic [15:0] lvl2_ff,   nxt_lvl2;
    logic [47:0] bpf_ff,    nxt_bpf;
    logic [47:0] bpc_ff,    nxt_bpc;
    logic [7:0]  warn_ff,   nxt_warn;
    logic [7:0]  out11_ff,  nxt_out11;
    logic [7:0]  relay_ff,  nxt_relay;
    logic [39:0] infn_ff,   nxt_infn;
    logic [15:0] rdata_ff,  nxt_rdata;

    // Pin synchronisers and trip state
    logic [5:0]  s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;
    mtta_state_t state_ff, nxt_state;
    logic [7:0]  code_ff, nxt_code;
    logic [31:0] tick_cnt_ff, nxt_tick_cnt;

    logic [15:0] eff_level;
    logic [7:0]  heat_pct;
    logic        heat_full;
    logic        heat_warn;
    logic [5:0]  rise;
    logic        reset_req;
    logic        tick;
    logic [N_CAUSE-1:0] hard_cause;
    logic [N_CAUSE-1:0] soft_cause;

    assign tick = (tick_cnt_ff == TICK_CYCLES - 1);

    mtta_curve mtta_curve_inst (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .curve_sel_in  (ctrl_ff[1:0]),
        .level_in      (ctrl_ff[CTRL_SET2_BIT] ? lvl2_ff : lvl1_ff),
        .freq_in       (freq_in),
        .bp_freq_in    (bpf_ff),
        .bp_cur_in     (bpc_ff),
        .eff_level_out (eff_level)
    );

    mtta_thermal_integ #(.FULL(FULL)) mtta_thermal_integ_inst (
        .clk_in       (clk_in),
        .sys_rst_in   (sys_rst_in),
        .tick_in      (tick),
        .current_in   (current_in),
        .eff_level_in (eff_level),
        .warn_thr_in  (warn_ff),
        .percent_out  (heat_pct),
        .full_out     (heat_full),
        .warn_out     (heat_warn)
    );

    // Register writes and registered read data
    always_comb
    begin
        nxt_ctrl  = ctrl_ff;
        nxt_lvl1  = lvl1_ff;
        nxt_lvl2  = lvl2_ff;
        nxt_bpf   = bpf_ff;
        nxt_bpc   = bpc_ff;
        nxt_warn  = warn_ff;
        nxt_out11 = out11_ff;
        nxt_relay = relay_ff;
        nxt_infn  = infn_ff;
        nxt_rdata = 16'h0000;
        if (wr_in)
        begin
            case (addr_in)
                REG_CTRL:
                    // Reserved curve code 3 falls back to constant torque
                    nxt_ctrl = (wdata_in[1:0] == 2'h3)
                             ? {wdata_in[2], CURVE_CONST}
                             : wdata_in[2:0];
                REG_LEVEL1: nxt_lvl1 = clamp(wdata_in, LEVEL_MIN, RATED_PM);
                REG_LEVEL2: nxt_lvl2 = clamp(wdata_in, LEVEL_MIN, RATED_PM);
                // Ordering of breakpoints is left to software
                REG_BP_FREQ0:
                    nxt_bpf[15:0]  = clamp(wdata_in, 16'h0000, BP_FREQ_MAX);
                REG_BP_FREQ0 + 5'h01:
                    nxt_bpf[31:16] = clamp(wdata_in, 16'h0000, BP_FREQ_MAX);
                REG_BP_FREQ0 + 5'h02:
                    nxt_bpf[47:32] = clamp(wdata_in, 16'h0000, BP_FREQ_MAX);
                REG_BP_CUR0:
                    nxt_bpc[15:0]  = clamp(wdata_in, 16'h0000, RATED_PM);
                REG_BP_CUR0 + 5'h01:
                    nxt_bpc[31:16] = clamp(wdata_in, 16'h0000, RATED_PM);
                REG_BP_CUR0 + 5'h02:
                    nxt_bpc[47:32] = clamp(wdata_in, 16'h0000, RATED_PM);
                REG_WARN_THR:
                    nxt_warn = (wdata_in[7:0] > WARN_MAX)
                             ? WARN_MAX : wdata_in[7:0];
                REG_OUT11_FN: nxt_out11 = wdata_in[7:0];
                REG_RELAY_FN: nxt_relay = wdata_in[7:0];
                REG_IN_FN0:           nxt_infn[7:0]   = wdata_in[7:0];
                REG_IN_FN0 + 5'h01:   nxt_infn[15:8]  = wdata_in[7:0];
                REG_IN_FN0 + 5'h02:   nxt_infn[23:16] = wdata_in[7:0];
                REG_IN_FN0 + 5'h03:   nxt_infn[31:24] = wdata_in[7:0];
                REG_IN_FN0 + 5'h04:   nxt_infn[39:32] = wdata_in[7:0];
                default: ;
            endcase
        end
        if (rd_in)
        begin
            case (addr_in)
                REG_CTRL:            nxt_rdata = {13'h0000, ctrl_ff};
                REG_LEVEL1:          nxt_rdata = lvl1_ff;
                REG_LEVEL2:          nxt_rdata = lvl2_ff;
                REG_BP_FREQ0:        nxt_rdata = bpf_ff[15:0];
                REG_BP_FREQ0 + 5'h01: nxt_rdata = bpf_ff[31:16];
                REG_BP_FREQ0 + 5'h02: nxt_rdata = bpf_ff[47:32];
                REG_BP_CUR0:         nxt_rdata = bpc_ff[15:0];
                REG_BP_CUR0 + 5'h01: nxt_rdata = bpc_ff[31:16];
                REG_BP_CUR0 + 5'h02: nxt_rdata = bpc_ff[47:32];
                REG_WARN_THR:        nxt_rdata = {8'h00, warn_ff};
                REG_OUT11_FN:        nxt_rdata = {8'h00, out11_ff};
                REG_RELAY_FN:        nxt_rdata = {8'h00, relay_ff};
                REG_IN_FN0:          nxt_rdata = {8'h00, infn_ff[7:0]};
                REG_IN_FN0 + 5'h01:  nxt_rdata = {8'h00, infn_ff[15:8]};
                REG_IN_FN0 + 5'h02:  nxt_rdata = {8'h00, infn_ff[23:16]};
                REG_IN_FN0 + 5'h03:  nxt_rdata = {8'h00, infn_ff[31:24]};
                REG_IN_FN0 + 5'h04:  nxt_rdata = {8'h00, infn_ff[39:32]};
                REG_STATUS:
                    nxt_rdata = {code_ff, 5'h00, heat_warn,
                                 state_ff == ST_LOCK, state_ff != ST_RUN};
                REG_MONITOR:         nxt_rdata = {8'h00, heat_pct};
                default:             nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_ff  <= {1'b0, CURVE_REDUCED};
            lvl1_ff  <= LEVEL_RST;
            lvl2_ff  <= LEVEL_RST;
            bpf_ff   <= 48'h0000_0000_0000;
            bpc_ff   <= 48'h0000_0000_0000;
            warn_ff  <= 8'h00;
            out11_ff <= OUT11_RST;
            relay_ff <= RELAY_RST;
            infn_ff  <= 40'h00_0000_0000;
            rdata_ff <= 16'h0000;
        end
        else
        begin
            ctrl_ff  <= nxt_ctrl;
            lvl1_ff  <= nxt_lvl1;
            lvl2_ff  <= nxt_lvl2;
            bpf_ff   <= nxt_bpf;
            bpc_ff   <= nxt_bpc;
            warn_ff  <= nxt_warn;
            out11_ff <= nxt_out11;
            relay_ff <= nxt_relay;
            infn_ff  <= nxt_infn;
            rdata_ff <= nxt_rdata;
        end
    end

    // Reset sources; a pin level counts once stages two and three agree
    always_comb
    begin
        nxt_lvl = lvl_ff;
        for (int i = 0; i < 6; i++)
            if (s2_ff[i] == s3_ff[i])
                nxt_lvl[i] = s3_ff[i];
        rise = nxt_lvl & ~lvl_ff;
        reset_req = rise[5];
        for (int i = 0; i < 5; i++)
            if (rise[i] && infn_ff[i*8 +: 8] == FN_RESET)
                reset_req = 1'b1;
    end

    // Trip state; a held cause re-trips right after its release
    always_comb
    begin
        hard_cause   = fault_cause_in & POWER_CYCLE[N_CAUSE-1:0];
        soft_cause   = fault_cause_in & ~POWER_CYCLE[N_CAUSE-1:0];
        nxt_state    = state_ff;
        nxt_code     = code_ff;
        nxt_tick_cnt = tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
        case (state_ff)
            ST_RUN:
            begin
                if (|hard_cause)
                    nxt_state = ST_LOCK;
                else if (|soft_cause || heat_full)
                    nxt_state = ST_TRIP;
                if (heat_full)
                    nxt_code = OVL_TRIP_CODE;
                for (int i = N_CAUSE - 1; i >= 0; i--)
                    if (fault_cause_in[i])
                        nxt_code = EXT_CODE_BASE + 8'(i);
            end
            ST_TRIP:
            begin
                if (|hard_cause)
                    nxt_state = ST_LOCK;
                else if (reset_req)
                begin
                    nxt_state = ST_RUN;
                    nxt_code  = 8'h00;
                end
            end
            ST_LOCK:
                nxt_state = ST_LOCK;
            default:
                nxt_state = ST_TRIP;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            s1_ff       <= 6'h00;
            s2_ff       <= 6'h00;
            s3_ff       <= 6'h00;
            lvl_ff      <= 6'h00;
            state_ff    <= ST_RUN;
            code_ff     <= 8'h00;
            tick_cnt_ff <= 32'h0000_0000;
        end
        else
        begin
            s1_ff       <= {panel_stop_reset_key_in, general_inputs_in};
            s2_ff       <= s1_ff;
            s3_ff       <= s2_ff;
            lvl_ff      <= nxt_lvl;
            state_ff    <= nxt_state;
            code_ff     <= nxt_code;
            tick_cnt_ff <= nxt_tick_cnt;
        end
    end

    assign rdata_out            = rdata_ff;
    assign power_enable_out     = (state_ff == ST_RUN);
    assign fault_indication_out = (state_ff != ST_RUN);
    assign overheat_warning_out = heat_warn;
    assign general_output_11_out = route(out11_ff, fault_indication_out,
                                         heat_warn);
    assign relay_output_out     = route(relay_ff, fault_indication_out,
                                        heat_warn);
    assign trip_code_out        = code_ff;

    sequence trip_held_s;
        state_ff == ST_TRIP && !(|hard_cause);
    endsequence
    sequence release_s;
        ##1 power_enable_out && !fault_indication_out;
    endsequence

    trip_entry_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_ff == ST_RUN && |soft_cause)
        |=> !power_enable_out && fault_indication_out)
        else $error("Anomaly did not trip");
    trip_release_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (trip_held_s and reset_req) |-> release_s)
        else $error("Reset did not release trip");
    lock_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_ff == ST_LOCK) |=> fault_indication_out [*8])
        else $error("Latched trip released");
    relay_fault_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (relay_ff == 8'h05) |-> relay_output_out == fault_indication_out)
        else $error("Relay not following fault");
    overload_code_a: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        (state_ff == ST_RUN && heat_full && !(|fault_cause_in))
        |=> state_ff == ST_TRIP && code_ff == 8'h05)
        else $error("Overload trip code wrong");
    level_range_a: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        lvl1_ff >= 16'h00C8 && lvl1_ff <= 16'h03E8)
        else $error("Protection level out of range");
    warn_route_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (out11_ff == 8'h0D) |-> general_output_11_out == heat_warn)
        else $error("Output 11 not following warning");
    curve_code_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ctrl_ff[1:0] != 2'h3)
        else $error("Illegal curve code held");
    monitor_rd_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && addr_in == 5'h12) |=> rdata_out == {8'h00, $past(heat_pct)})
        else $error("Monitor read wrong");
endmodule
`default_nettype wire

//--- tb/mtta_top_tb.sv
// Self-checking bench for the motor thermal trip and alarm block
`timescale 1ns/1ps
`default_nettype none
module mtta_top_tb;
    import mtta_pkg::*;
    logic        clk_in     = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [4:0]  addr_in    = 5'h00;
    logic [15:0] wdata_in   = 16'h0000;
    logic        wr_in      = 1'b0;
    logic        rd_in      = 1'b0;
    logic [7:0]  cause      = 8'h00;
    logic        key        = 1'b0;
    logic [4:0]  gin        = 5'h00;
    logic [15:0] current_in = 16'h0000;
    logic [15:0] rdata_out;
    logic        pwr, flt, warn, out11, relay;
    logic [7:0]  code;
    logic [15:0] d;
    int          errors     = 0;
    int          n_compared = 0;
    mtta_top #(.TICK_CYCLES(4), .FULL(1000)) mtta_top_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .fault_cause_in(cause),
        .panel_stop_reset_key_in(key), .general_inputs_in(gin),
        .current_in(current_in), .freq_in(16'h0032),
        .power_enable_out(pwr), .fault_indication_out(flt),
        .overheat_warning_out(warn), .general_output_11_out(out11),
        .relay_output_out(relay), .trip_code_out(code));
    initial
    begin
        forever #20 clk_in = ~clk_in;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk_in);
        addr_in <= a; wdata_in <= v; wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clk_in);
        addr_in <= a; rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // Pins pass a 3-stage synchroniser, so hold well past it
    task automatic press(input logic use_key);
        @(posedge clk_in);
        if (use_key) key <= 1'b1; else gin <= 5'h01;
        repeat (8) @(posedge clk_in);
        key <= 1'b0; gin <= 5'h00;
        repeat (6) @(posedge clk_in);
        #1;
    endtask
    task automatic t_reset;
        chk(pwr, 1'b1); chk(flt, 1'b0); chk(code, 8'h00);
        rd(REG_RELAY_FN); chk(d, 16'h0005);
        rd(REG_LEVEL1); chk(d, 16'h03E8);
        wr(REG_LEVEL2, 16'h0010); rd(REG_LEVEL2); chk(d, 16'h00C8);
        rd(5'h1F); chk(d, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_trip;
        wr(REG_IN_FN0, 16'h0012);
        @(posedge clk_in); cause <= 8'h04;
        repeat (3) @(posedge clk_in);
        cause <= 8'h00;
        #1 chk(flt, 1'b1); chk(pwr, 1'b0); chk(code, 8'h12);
        chk(relay, 1'b1);
        press(1'b0); chk(flt, 1'b0); chk(pwr, 1'b1);
        chk(relay, 1'b0); chk(code, 8'h00);
        $display("test trip done");
    endtask
    task automatic t_lock;
        @(posedge clk_in); cause <= 8'h80;
        repeat (3) @(posedge clk_in);
        cause <= 8'h00;
        press(1'b1); chk(flt, 1'b1);
        rd(REG_STATUS); chk(d, 16'h1703);
        @(posedge clk_in); sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in); #1 chk(flt, 1'b0); chk(pwr, 1'b1);
        $display("test lock done");
    endtask
    // Free curve at 50 Hz picks the third breakpoint current
    task automatic t_free;
        wr(REG_BP_FREQ0, 16'h000A);
        wr(REG_BP_FREQ0 + 5'h01, 16'h0028);
        wr(REG_BP_FREQ0 + 5'h02, 16'h0064);
        wr(REG_BP_CUR0 + 5'h02, 16'h0300);
        wr(REG_CTRL, 16'h0002);
        rd(REG_BP_CUR0 + 5'h02); chk(d, 16'h0300);
        @(posedge clk_in); current_in <= 16'h0300;
        repeat (12) @(posedge clk_in);
        #1 rd(REG_MONITOR); chk(d, 16'h0000);
        @(posedge clk_in); current_in <= 16'h0364;
        repeat (12) @(posedge clk_in);
        #1 rd(REG_MONITOR); chk(d != 16'h0000, 1'b1);
        chk(flt, 1'b0);
        @(posedge clk_in); current_in <= 16'h0000;
        $display("test free curve done");
    endtask
    // Heat grows 10 % a tick, so warning lands well before the trip
    task automatic t_therm;
        wr(REG_CTRL, 16'h0001); wr(REG_WARN_THR, 16'h0032);
        wr(REG_OUT11_FN, 16'h000D);
        @(posedge clk_in); current_in <= 16'h044C;
        for (int i = 0; i < 300 && out11 !== 1'b1; i++) @(posedge clk_in);
        #1 chk(out11, 1'b1); chk(warn, 1'b1); chk(flt, 1'b0);
        rd(REG_MONITOR); chk(d >= 16'h0032 && d < 16'h0064, 1'b1);
        for (int i = 0; i < 300 && flt !== 1'b1; i++) @(posedge clk_in);
        #1 chk(flt, 1'b1); chk(code, OVL_TRIP_CODE);
        chk(pwr, 1'b0);
        $display("test thermal done");
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset(); t_trip(); t_lock(); t_free(); t_therm();
        tally_and_finish();
    end
    initial
    begin
        #400000;
        errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
